// [core/dtm_map.svh]
// Register addresses, field positions and constants for the dual timer
`ifndef DTM_MAP_SVH
`define DTM_MAP_SVH
`define DTM_ADDR_A 16'hff4d
`define DTM_ADDR_B 16'hff4e
`define DTM_RESET_VAL 8'h00
`define DTM_RUN 7
`define DTM_EDGE 6
`define DTM_OE2 6
`define DTM_CLK_HI 5
`define DTM_CLK_LO 3
`define DTM_MODE_HI 2
`define DTM_MODE_LO 1
`define DTM_OE 0
`define DTM_DIV4 2'h3
`define DTM_DIV8 3'h7
`define DTM_DIV128 7'h7f
`define DTM_ZERO 8'h00
`define DTM_FULL 8'hff
`endif

// [core/dtm_pkg.sv]
// Types shared by the dual timer
package dtm_pkg;
  typedef enum logic [3:0] {
    dtm_discrete = 4'h0,
    dtm_cascade = 4'h5,
    dtm_carrier = 4'h3,
    dtm_a_disc_b_pwm = 4'h2,
    dtm_both_pwm = 4'ha,
    dtm_a_pwm_b_disc = 4'h8
  } dtm_mode_type;
  typedef struct packed {
    logic [7:0] compare_a;
    logic [7:0] compare_b;
    logic [7:0] high_width_compare;
  } dtm_cmp_type;
  typedef struct packed {
    logic wr;
    logic bit_op;
    logic [2:0] bit_sel;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dtm_bus_type;
endpackage

// [core/dtm_timer.sv]
// Dual 8-bit timer mode control, counters and output gating
`timescale 1ns/100ps
`include "dtm_map.svh"
module dtm_timer (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire dtm_pkg::dtm_bus_type bus_in,
  input wire logic [15:0] raddr_in,
  input wire dtm_pkg::dtm_cmp_type cmp_in,
  input wire logic sub_clock_in,
  input wire logic external_count_input_in,
  input wire logic carrier_clock_in,
  output logic [7:0] rdata_out,
  output logic [7:0] counter_a_out,
  output logic [7:0] counter_b_out,
  output logic timer_a_out_pin_out,
  output logic timer_b_first_out_pin_out,
  output logic timer_b_second_out_pin_out
);
  import dtm_pkg::*;

  // Apply a byte or a single-bit write to a register
  function automatic logic [7:0] apply_wr(input logic [7:0] cur,
                                          input dtm_bus_type b);
    logic [7:0] r;
    r = cur;
    if (b.bit_op) begin
      r[b.bit_sel] = b.wdata[0];
    end else begin
      r = b.wdata;
    end
    return r;
  endfunction

  logic [7:0] timer_a_mode_control, timer_b_mode_control;
  logic [7:0] next_timer_a_mode_control, next_timer_b_mode_control;
  logic [7:0] counter_a, counter_b, next_counter_a, next_counter_b;
  logic [6:0] prescale, next_prescale;
  logic [2:0] ext_div, next_ext_div;
  logic sub_q, ext_q, match_b_q, out_b_q, carrier_q, clk_a_q;
  logic next_sub_q, next_ext_q, next_match_b_q, next_carrier_q, next_clk_a_q;
  logic out_a, out_b, next_out_a, next_out_b;
  logic [7:0] next_rdata;
  dtm_mode_type mode;
  logic run_a, run_b, tick_a, tick_b, src_a, match_a, match_b;
  logic ext_rise;

  // Register writes; prohibited codes are stored as written
  always_comb begin
    next_timer_a_mode_control = timer_a_mode_control;
    next_timer_b_mode_control = timer_b_mode_control;
    if (bus_in.wr && bus_in.addr == `DTM_ADDR_A) begin
      next_timer_a_mode_control =
        apply_wr(timer_a_mode_control, bus_in);
    end
    if (bus_in.wr && bus_in.addr == `DTM_ADDR_B) begin
      next_timer_b_mode_control =
        apply_wr(timer_b_mode_control, bus_in);
    end
    next_rdata = `DTM_ZERO;
    if (raddr_in == `DTM_ADDR_A) begin
      next_rdata = timer_a_mode_control;
    end else if (raddr_in == `DTM_ADDR_B) begin
      next_rdata = timer_b_mode_control;
    end
  end

  // Joint mode taken from both registers, A mode field in the upper two bits, B in the lower two
  assign mode = dtm_mode_type'(
    {timer_a_mode_control[`DTM_MODE_HI:`DTM_MODE_LO],
     timer_b_mode_control[`DTM_MODE_HI:`DTM_MODE_LO]});
  assign run_b = timer_b_mode_control[`DTM_RUN];
  assign run_a = (mode == dtm_cascade) ? run_b
                 : timer_a_mode_control[`DTM_RUN];
  assign match_a = counter_a == cmp_in.compare_a;
  assign match_b = (mode == dtm_a_disc_b_pwm || mode == dtm_both_pwm)
                   ? counter_b == cmp_in.high_width_compare
                   : counter_b == cmp_in.compare_b;
  assign ext_rise = external_count_input_in && !ext_q;

  // Timer B count source select
  always_comb begin
    case (timer_b_mode_control[`DTM_CLK_HI:`DTM_CLK_LO])
      3'h0: tick_b = 1'b1;
      3'h1: tick_b = prescale[1:0] == `DTM_DIV4;
      3'h2: tick_b = ext_rise;
      3'h3: tick_b = ext_rise && ext_div[0];
      3'h4: tick_b = ext_rise && ext_div[1:0] == `DTM_DIV4;
      3'h5: tick_b = ext_rise && ext_div == `DTM_DIV8;
      default: tick_b = 1'b0;
    endcase
  end

  // Timer A count source; level sources edge-detected against clk_a_q
  always_comb begin
    src_a = 1'b0;
    tick_a = 1'b0;
    if (mode == dtm_cascade) begin
      tick_a = tick_b;
    end else begin
      case (timer_a_mode_control[`DTM_CLK_HI:`DTM_CLK_LO])
        3'h0: tick_a = 1'b1;
        3'h1: tick_a = prescale[2:0] == `DTM_DIV8;
        3'h2: tick_a = prescale == `DTM_DIV128;
        3'h3: src_a = sub_q;
        3'h4: src_a = match_b_q;
        3'h5: src_a = (mode == dtm_carrier) ? carrier_q : out_b_q;
        default: src_a = 1'b0;
      endcase
      // Both edges only in PWM modes of timer A
      if (timer_a_mode_control[`DTM_CLK_HI:`DTM_CLK_LO] >= 3'h3 &&
          timer_a_mode_control[`DTM_CLK_HI:`DTM_CLK_LO] <= 3'h5) begin
        tick_a = (timer_a_mode_control[`DTM_EDGE] &&
                  (mode == dtm_both_pwm || mode == dtm_a_pwm_b_disc))
                 ? src_a != clk_a_q
                 : src_a && !clk_a_q;
      end
    end
  end

  // Counter next values and clear conditions
  always_comb begin
    next_prescale = prescale + 7'h01;
    next_ext_div = ext_rise ? ext_div + 3'h1 : ext_div;
    next_sub_q = sub_clock_in;
    next_ext_q = external_count_input_in;
    next_carrier_q = carrier_clock_in;
    next_clk_a_q = src_a;
    next_counter_a = counter_a;
    next_counter_b = counter_b;
    next_out_a = out_a;
    next_out_b = out_b;
    next_match_b_q = 1'b0;
    if (!run_b) begin
      next_counter_b = `DTM_ZERO;
      next_out_b = 1'b0;
    end else if (tick_b) begin
      if (mode == dtm_cascade) begin
        // Upper byte advances when the lower byte wraps
        if (tick_a && counter_a == `DTM_FULL) begin
          next_counter_b = counter_b + 8'h01;
        end
      end else if (match_b || counter_b == `DTM_FULL) begin
        next_counter_b = `DTM_ZERO;
        next_match_b_q = match_b;
        next_out_b = !out_b;
      end else begin
        next_counter_b = counter_b + 8'h01;
      end
    end
    if (!run_a) begin
      next_counter_a = `DTM_ZERO;
      next_out_a = 1'b0;
    end else if (tick_a) begin
      if (mode == dtm_cascade) begin
        if (match_a && match_b) begin
          next_counter_a = `DTM_ZERO;
          next_counter_b = `DTM_ZERO;
          next_out_a = !out_a;
        end else begin
          next_counter_a = counter_a + 8'h01;
        end
      end else if (match_a || counter_a == `DTM_FULL) begin
        next_counter_a = `DTM_ZERO;
        next_out_a = !out_a;
      end else begin
        next_counter_a = counter_a + 8'h01;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      timer_a_mode_control <= `DTM_RESET_VAL;
      timer_b_mode_control <= `DTM_RESET_VAL;
      counter_a <= `DTM_ZERO;
      counter_b <= `DTM_ZERO;
      prescale <= 7'h00;
      ext_div <= 3'h0;
      sub_q <= 1'b0;
      ext_q <= 1'b0;
      carrier_q <= 1'b0;
      clk_a_q <= 1'b0;
      match_b_q <= 1'b0;
      out_b_q <= 1'b0;
      out_a <= 1'b0;
      out_b <= 1'b0;
      rdata_out <= `DTM_ZERO;
    end else begin
      timer_a_mode_control <= next_timer_a_mode_control;
      timer_b_mode_control <= next_timer_b_mode_control;
      counter_a <= next_counter_a;
      counter_b <= next_counter_b;
      prescale <= next_prescale;
      ext_div <= next_ext_div;
      sub_q <= next_sub_q;
      ext_q <= next_ext_q;
      carrier_q <= next_carrier_q;
      clk_a_q <= next_clk_a_q;
      match_b_q <= next_match_b_q;
      out_b_q <= next_out_b;
      out_a <= next_out_a;
      out_b <= next_out_b;
      rdata_out <= next_rdata;
    end
  end

  assign counter_a_out = counter_a;
  assign counter_b_out = counter_b;
  // Output gating; code 11 of the B enables drives neither pin
  assign timer_a_out_pin_out = out_a
    && timer_a_mode_control[`DTM_OE];
  assign timer_b_first_out_pin_out = out_b && timer_b_mode_control[`DTM_OE]
    && !timer_b_mode_control[`DTM_OE2];
  assign timer_b_second_out_pin_out = out_b && timer_b_mode_control[`DTM_OE2]
    && !timer_b_mode_control[`DTM_OE];

  AST_RUN_A_CLEAR: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !run_a |=> counter_a == `DTM_ZERO) else $error("counter A not cleared");
  AST_RUN_B_CLEAR: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !run_b |=> counter_b == `DTM_ZERO) else $error("counter B not cleared");
  AST_PWM_HW: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (mode == dtm_both_pwm && run_b && tick_b && match_b)
    |=> counter_b == `DTM_ZERO) else $error("B not cleared on match");
  AST_CASC_RUN: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (mode == dtm_cascade && !run_b && $past(mode) == dtm_cascade)
    |-> ##1 counter_a == `DTM_ZERO) else $error("cascade clear lost");
  AST_OE_A: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !timer_a_mode_control[`DTM_OE] |-> !timer_a_out_pin_out)
    else $error("A pin not gated");
  AST_OE_B: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !(timer_b_first_out_pin_out && timer_b_second_out_pin_out))
    else $error("both B pins active");
  AST_WR_A: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.wr && !bus_in.bit_op && bus_in.addr == `DTM_ADDR_A)
    |=> timer_a_mode_control == $past(bus_in.wdata))
    else $error("A write lost");
  AST_RD_B: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    raddr_in == `DTM_ADDR_B |=> rdata_out == $past(timer_b_mode_control))
    else $error("B readback wrong");
  AST_MAIN_CLK: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (run_b && mode == dtm_discrete && !match_b && counter_b != `DTM_FULL
     && timer_b_mode_control[`DTM_CLK_HI:`DTM_CLK_LO] == 3'h0)
    |=> counter_b == $past(counter_b) + 8'h01) else $error("B no count");
endmodule

// [testbench/dtm_cpu.sv]
// CPU model that programs and reads the timer mode registers
`timescale 1ns/100ps
`include "dtm_map.svh"
module dtm_cpu (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output dtm_pkg::dtm_bus_type bus_out,
  output logic [15:0] raddr_out
);
  import dtm_pkg::*;
  // Quiet bus from time zero
  initial begin
    bus_out = '0;
    raddr_out = 16'h0000;
  end
  // One-cycle strobe; released lines show inverted junk, not old data
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic bo, input logic [2:0] s);
    @(posedge clk_in);
    bus_out <= '{1'b1, bo, s, a, d};
    @(posedge clk_in);
    bus_out <= '{1'b0, 1'b0, ~s, ~a, ~d};
  endtask
  // Read data is registered, so it is taken one edge later
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_in);
    raddr_out <= a;
    @(posedge clk_in);
    #1 d = rdata_in;
  endtask
  // Stop both, program mode and clock, then start; mode goes to both
  task automatic setup(input logic [7:0] a, input logic [7:0] b);
    wr(`DTM_ADDR_B, 8'h00, 1'b0, 3'h0);
    wr(`DTM_ADDR_A, 8'h00, 1'b0, 3'h0);
    wr(`DTM_ADDR_A, a & 8'h7f, 1'b0, 3'h0);
    wr(`DTM_ADDR_B, b & 8'h7f, 1'b0, 3'h0);
    wr(`DTM_ADDR_A, a, 1'b0, 3'h0);
    wr(`DTM_ADDR_B, b, 1'b0, 3'h0);
  endtask
endmodule

// [testbench/test_dual_8bit_timer_mode_control.sv]
// Self-checking bench for the dual timer mode control block
`timescale 1ns/100ps
module test_dual_8bit_timer_mode_control;
  import dtm_pkg::*;
  localparam logic [15:0] ad_a = 16'hff4d;
  localparam logic [15:0] ad_b = 16'hff4e;
  logic clk_in = 1'b0, resetn_in = 1'b0, sub_clk = 1'b0, ext_in = 1'b0;
  logic car_clk = 1'b0;
  logic pin_a, pin_b1, pin_b2;
  logic [2:0] s;
  logic [7:0] rdata, counter_a, counter_b, v, tick = 8'h00;
  logic [15:0] raddr;
  dtm_bus_type bus;
  dtm_cmp_type cmp = '{8'hff, 8'hff, 8'hff};
  int errors = 0, compares = 0;
  int eb[6] = '{64, 16, 16, 8, 4, 2};
  int ea[4] = '{32, 2, 16, 64};
  logic [7:0] pa[6] = '{8'h80, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] pb[6] = '{8'h00, 8'h00, 8'h80, 8'h81, 8'hc0, 8'hc1};
  logic [2:0] pe[6] = '{3'h0, 3'h4, 3'h0, 3'h2, 3'h1, 3'h0};
  // System clock
  always #10 clk_in = ~clk_in;
  // Slow count sources, moved only on the system clock edge
  always @(posedge clk_in) begin
    tick <= tick + 8'h01;
    sub_clk <= tick[3];
    ext_in <= tick[1];
    car_clk <= tick[4];
  end
  dtm_cpu cpu (.clk_in(clk_in), .rdata_in(rdata), .bus_out(bus),
    .raddr_out(raddr));
  dtm_timer dut (.clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus),
    .raddr_in(raddr), .cmp_in(cmp), .sub_clock_in(sub_clk),
    .external_count_input_in(ext_in), .carrier_clock_in(car_clk),
    .rdata_out(rdata), .counter_a_out(counter_a),
    .counter_b_out(counter_b), .timer_a_out_pin_out(pin_a),
    .timer_b_first_out_pin_out(pin_b1),
    .timer_b_second_out_pin_out(pin_b2));
  // Range compare; an unknown never lands inside the range
  task automatic chk(input logic [7:0] g, input logic [7:0] lo,
                     input logic [7:0] hi);
    compares++;
    if (((g >= lo) && (g <= hi)) !== 1'b1) begin
      errors++;
      $display("[ERR] %0t got %h want %h..%h", $time, g, lo, hi);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    cpu.rd(a, v);
    chk(v, e, e);
  endtask
  // Count over a span; slack of two covers the start edge
  task automatic meas(input logic [7:0] a, input logic [7:0] b,
                      input int n, input logic use_b, input int e);
    cpu.setup(a, b);
    repeat (n) @(posedge clk_in);
    #1 chk(use_b ? counter_b : counter_a,
      8'((e > 2) ? e - 2 : (e > 0) ? e - 1 : 0), 8'(e + 2));
  endtask
  // The counter clears on the edge after the run bit drops
  task automatic stop(input logic [15:0] a, input logic [7:0] d,
                      input logic use_b);
    cpu.wr(a, d & 8'h7f, 1'b0, 3'h0);
    @(posedge clk_in);
    #1 chk(use_b ? counter_b : counter_a, 8'h00, 8'h00);
  endtask
  // Peak of counter B and which pins ever went high
  task automatic watch(output logic [7:0] mx, output logic [2:0] sn);
    mx = 8'h00;
    sn = 3'h0;
    repeat (40) begin
      @(posedge clk_in);
      #1 mx = (counter_b > mx) ? counter_b : mx;
      sn = sn | {pin_a, pin_b1, pin_b2};
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    rchk(ad_a, 8'h00);
    rchk(ad_b, 8'h00);
    cpu.wr(ad_a, 8'h3e, 1'b0, 3'h0);
    cpu.wr(ad_b, 8'h7f, 1'b0, 3'h0);
    rchk(ad_a, 8'h3e);
    rchk(ad_b, 8'h7f);
    cpu.wr(ad_a, 8'h00, 1'b1, 3'h2);
    cpu.wr(ad_b, 8'h00, 1'b1, 3'h6);
    cpu.wr(16'hff4f, 8'h55, 1'b0, 3'h0);
    rchk(ad_a, 8'h3a);
    rchk(ad_b, 8'h3f);
    rchk(16'hff4f, 8'h00);
    $display("registers done");
    for (int i = 0; i < 6; i++) begin
      meas(8'h00, 8'h80 | 8'(i << 3), 64, 1'b1, eb[i]);
    end
    stop(ad_b, 8'ha8, 1'b1);
    cmp.compare_b <= 8'h03;
    for (int i = 0; i < 4; i++) begin
      meas(8'h80 | 8'((i + 1) << 3), {i == 3, 7'h00}, 256, 1'b0,
        ea[i]);
    end
    meas(8'ha8, 8'h80, 256, 1'b0, 32);
    meas(8'ha8, 8'h86, 256, 1'b0, 8);
    meas(8'hd8, 8'h00, 256, 1'b0, 16);
    meas(8'hdc, 8'h00, 256, 1'b0, 32);
    stop(ad_a, 8'h5c, 1'b0);
    $display("clocks done");
    cmp.compare_b <= 8'hff;
    meas(8'h9a, 8'h02, 64, 1'b0, 0);
    meas(8'h1a, 8'h82, 64, 1'b0, 64);
    meas(8'h1a, 8'h82, 260, 1'b0, 4);
    chk(counter_b, 8'h01, 8'h01);
    stop(ad_b, 8'h82, 1'b0);
    $display("cascade done");
    cmp <= '{8'h03, 8'hc8, 8'h05};
    cpu.setup(8'h00, 8'h84);
    watch(v, s);
    chk(v, 8'h04, 8'h05);
    cpu.setup(8'h84, 8'h84);
    watch(v, s);
    chk(v, 8'h04, 8'h05);
    stop(ad_b, 8'h84, 1'b1);
    $display("pwm done");
    cmp.compare_b <= 8'h03;
    for (int i = 0; i < 6; i++) begin
      cpu.setup(pa[i], pb[i]);
      watch(v, s);
      chk({5'h00, s}, {5'h00, pe[i]}, {5'h00, pe[i]});
    end
    $display("outputs done");
    end_of_test();
  end
  // Watchdog, about three times the expected run
  initial begin
    repeat (10000) @(posedge clk_in);
    errors++;
    end_of_test();
  end
endmodule
